/* src/cct_pkg.sv */
// Purpose: shared constants and types for the capture compare timer
// Assumes: avalon-mm register map with 32-bit registers at byte addresses
// Notes:   register offsets are byte addresses
package cct_pkg;
    localparam int          CCT_CW         = 16;
    localparam logic [7:0]  CCT_OFS_RUN    = 8'h00;
    localparam logic [7:0]  CCT_OFS_MODE   = 8'h04;
    localparam logic [7:0]  CCT_OFS_CTRL   = 8'h08;
    localparam logic [7:0]  CCT_OFS_FLOP   = 8'h0C;
    localparam logic [7:0]  CCT_OFS_CMP0   = 8'h10;
    localparam logic [7:0]  CCT_OFS_CMP1   = 8'h14;
    localparam logic [7:0]  CCT_OFS_CAP0   = 8'h18;
    localparam logic [7:0]  CCT_OFS_CAP1   = 8'h1C;
    localparam logic [7:0]  CCT_OFS_SNAP   = 8'h20;
    localparam logic [7:0]  CCT_OFS_STAT   = 8'h24;
    // mode register fields
    localparam int          CCT_B_CLK      = 0;
    localparam int          CCT_B_CLE      = 2;
    localparam int          CCT_B_CPM      = 3;
    localparam int          CCT_B_SWCAP    = 5;
    // flop control fields
    localparam int          CCT_B_FCMD     = 0;
    localparam int          CCT_B_TEN      = 2;
    // buffer enable and prescaler select fields in control register
    localparam int          CCT_B_BUF      = 7;
    localparam int          CCT_B_PRCK     = 8;
    localparam logic [1:0]  CCT_SRC_T1     = 2'h1;
    localparam logic [1:0]  CCT_SRC_T4     = 2'h2;
    localparam logic [1:0]  CCT_SRC_T16    = 2'h3;
    localparam logic [1:0]  CCT_SRC_EXT    = 2'h0;
    localparam logic [1:0]  CCT_FF_TOGGLE  = 2'h0;
    localparam logic [1:0]  CCT_FF_SET     = 2'h1;
    localparam logic [1:0]  CCT_FF_CLEAR   = 2'h2;
    localparam logic [1:0]  CCT_CPM_OFF    = 2'h0;
    localparam logic [1:0]  CCT_CPM_RISE   = 2'h1;
    localparam logic [1:0]  CCT_CPM_BOTH   = 2'h2;
    localparam logic [1:0]  CCT_CPM_MATCH  = 2'h3;
    localparam int          CCT_PRE_W      = 10;
    localparam int          CCT_TAP1       = 0;
    localparam int          CCT_TAP4       = 2;
    localparam int          CCT_TAP16      = 4;
    localparam logic [2:0]  CCT_PRCK_MAX   = 3'h5;

    typedef struct packed {
        logic [CCT_CW-1:0] cmp0;
        logic [CCT_CW-1:0] cmp1;
    } cct_cmp_t;

    typedef struct packed {
        logic match0;
        logic match1;
        logic cap0;
        logic cap1;
        logic ovf;
    } cct_evt_t;
endpackage : cct_pkg

/* src/cct_prescaler.sv */
// Purpose: prescaler clock and three tick taps
// Assumes: runs from the peripheral clock
// Notes:   prescaler clock is the peripheral clock divided by 1 to 32
`timescale 1ns/1ps
module cct_prescaler
    import cct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] prck,
    output logic [2:0]      taps
);
    logic [CCT_PRE_W-1:0] divCount;
    logic [CCT_PRE_W-1:0] next_divCount;
    logic [2:0]           sel;

    // clamp out-of-range prescaler selections
    assign sel = (prck > CCT_PRCK_MAX) ? CCT_PRCK_MAX : prck;

    // free running divider
    always_comb begin
        next_divCount = divCount + {{(CCT_PRE_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            divCount <= '0;
        end else begin
            divCount <= next_divCount;
        end
    end

    // tap pulses at divide by 2, 8 and 32 of the prescaler clock
    always_comb begin
        logic [CCT_PRE_W:0] ext;
        int                 base;
        ext  = {divCount, 1'b1};
        base = int'(sel);
        taps[0] = (ext[base + CCT_TAP1 +: 1] == 1'b1)
                  && ((divCount & ((CCT_PRE_W'(1) << (base + 1)) - CCT_PRE_W'(1)))
                      == ((CCT_PRE_W'(1) << (base + 1)) - CCT_PRE_W'(1)));
        taps[1] = (divCount & ((CCT_PRE_W'(1) << (base + CCT_TAP4 + 1)) - CCT_PRE_W'(1)))
                  == ((CCT_PRE_W'(1) << (base + CCT_TAP4 + 1)) - CCT_PRE_W'(1));
        taps[2] = (divCount & ((CCT_PRE_W'(1) << (base + CCT_TAP16 + 1)) - CCT_PRE_W'(1)))
                  == ((CCT_PRE_W'(1) << (base + CCT_TAP16 + 1)) - CCT_PRE_W'(1));
    end
endmodule : cct_prescaler

/* src/cct_edge_sync.sv */
// Purpose: two-flop synchroniser with rising and falling edge pulses
// Assumes: asynchronous pin input
// Notes:   the first flop feeds only the second
`timescale 1ns/1ps
module cct_edge_sync (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pinIn,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic prev;

    // synchroniser and edge history
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pinIn;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule : cct_edge_sync

/* src/cct_timer.sv */
// Purpose: 16-bit capture compare timer channel with avalon-mm registers
// Assumes: single clock, synchronous reset, external pin is asynchronous
// Notes:   interrupt outputs are one-cycle event pulses
`timescale 1ns/1ps
module cct_timer
    import cct_pkg::*;
#(
    parameter int CW = CCT_CW
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        event_input_pin,
    output logic             timer_output_pin,
    output logic             timer_interrupt,
    output logic             capture_zero_interrupt,
    output logic             capture_one_interrupt
);
    logic [CW-1:0] up_counter;
    logic          count_run_bit;
    logic [1:0]    source_clock_select;
    logic          clear_on_match_enable;
    logic [1:0]    capture_timing_select;
    logic          buffer_enable_bit;
    logic [2:0]    prescalerSelect;
    logic [3:0]    toggleEnable;
    logic          output_toggle_flop;
    cct_cmp_t      compareActive;
    cct_cmp_t      compareBuffer;
    logic [CW-1:0] capture_value_zero;
    logic [CW-1:0] capture_value_one;
    cct_evt_t      evt;
    logic [4:0]    stickyStat;
    logic [2:0]    taps;
    logic          pinRise;
    logic          pinFall;
    logic          tick;
    logic          wrStrobe;
    logic          rdPhase;
    logic          wrRun;
    logic          wrMode;
    logic          wrCtrl;
    logic          wrFlop;
    logic          wrCmp0;
    logic          wrCmp1;
    logic          wrStat;
    logic          swCapture;

    // full byte address decode used by both read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : hit

    cct_prescaler u_pre (
        .clk     (clk),
        .sys_rst (sys_rst),
        .prck    (prescalerSelect),
        .taps    (taps)
    );

    cct_edge_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pinIn   (event_input_pin),
        .rise    (pinRise),
        .fall    (pinFall)
    );

    // bus: writes in one cycle, reads take one wait cycle
    assign wrStrobe        = avs_write & avs_byteenable[0];
    assign avs_waitrequest = avs_read & ~rdPhase;
    assign wrRun           = wrStrobe & hit(avs_address, CCT_OFS_RUN);
    assign wrMode          = wrStrobe & hit(avs_address, CCT_OFS_MODE);
    assign wrCtrl          = avs_write & hit(avs_address, CCT_OFS_CTRL);
    assign wrFlop          = wrStrobe & hit(avs_address, CCT_OFS_FLOP);
    assign wrCmp0          = avs_write & hit(avs_address, CCT_OFS_CMP0);
    assign wrCmp1          = avs_write & hit(avs_address, CCT_OFS_CMP1);
    assign wrStat          = wrStrobe & hit(avs_address, CCT_OFS_STAT);
    assign swCapture       = wrMode & ~avs_writedata[CCT_B_SWCAP];

    // read wait-state toggle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdPhase <= 1'b0;
        end else begin
            rdPhase <= avs_read & ~rdPhase;
        end
    end

    // read data registered at the wait cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read & ~rdPhase) begin
            unique case (1'b1)
                hit(avs_address, CCT_OFS_RUN):  avs_readdata <= {31'h0000_0000, count_run_bit};
                hit(avs_address, CCT_OFS_MODE): avs_readdata <= {26'h000_0000, 1'b1,
                    capture_timing_select, clear_on_match_enable, source_clock_select};
                hit(avs_address, CCT_OFS_CTRL): avs_readdata <= {21'h00_0000,
                    prescalerSelect, buffer_enable_bit, 7'h00};
                hit(avs_address, CCT_OFS_FLOP): avs_readdata <= {26'h000_0000,
                    toggleEnable, 2'h3};
                hit(avs_address, CCT_OFS_CMP0): avs_readdata <= 32'(compareActive.cmp0);
                hit(avs_address, CCT_OFS_CMP1): avs_readdata <= 32'(compareActive.cmp1);
                hit(avs_address, CCT_OFS_CAP0): avs_readdata <= 32'(capture_value_zero);
                hit(avs_address, CCT_OFS_CAP1): avs_readdata <= 32'(capture_value_one);
                hit(avs_address, CCT_OFS_SNAP): avs_readdata <= 32'(up_counter);
                hit(avs_address, CCT_OFS_STAT): avs_readdata <= {26'h000_0000,
                    output_toggle_flop, stickyStat};
                default:                        avs_readdata <= '0;
            endcase
        end
    end

    // run and mode registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_run_bit         <= 1'b0;
            source_clock_select   <= CCT_SRC_EXT;
            clear_on_match_enable <= 1'b0;
            capture_timing_select <= CCT_CPM_OFF;
        end else begin
            if (wrRun) begin
                count_run_bit <= avs_writedata[0];
            end
            if (wrMode) begin
                source_clock_select   <= avs_writedata[CCT_B_CLK +: 2];
                clear_on_match_enable <= avs_writedata[CCT_B_CLE];
                capture_timing_select <= avs_writedata[CCT_B_CPM +: 2];
            end
        end
    end

    // control: buffer enable and prescaler select
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buffer_enable_bit <= 1'b0;
            prescalerSelect   <= '0;
        end else begin
            if (wrCtrl & avs_byteenable[0]) begin
                buffer_enable_bit <= avs_writedata[CCT_B_BUF];
            end
            if (wrCtrl & avs_byteenable[1]) begin
                prescalerSelect <= avs_writedata[CCT_B_PRCK +: 3];
            end
        end
    end

    // source tick selection
    always_comb begin
        case (source_clock_select)
            CCT_SRC_T1:  tick = taps[0];
            CCT_SRC_T4:  tick = taps[1];
            CCT_SRC_T16: tick = taps[2];
            default:     tick = pinRise;
        endcase
    end

    // comparators
    assign evt.match0 = count_run_bit & (up_counter == compareActive.cmp0);
    assign evt.match1 = count_run_bit & (up_counter == compareActive.cmp1);

    // up-counter with stop clear, match clear and overflow
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            up_counter <= '0;
        end else if (!count_run_bit) begin
            up_counter <= '0;
        end else if (tick) begin
            if (clear_on_match_enable && evt.match1) begin
                up_counter <= '0;
            end else begin
                up_counter <= up_counter + CW'(1);
            end
        end
    end

    assign evt.ovf = count_run_bit & tick & (&up_counter)
                     & ~(clear_on_match_enable & evt.match1);

    // match pulse only on the first cycle of equality
    logic match0Seen;
    logic match1Seen;
    logic match0Evt;
    logic match1Evt;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            match0Seen <= 1'b0;
            match1Seen <= 1'b0;
        end else begin
            match0Seen <= evt.match0;
            match1Seen <= evt.match1;
        end
    end
    assign match0Evt = evt.match0 & ~match0Seen;
    assign match1Evt = evt.match1 & ~match1Seen;

    // reload strobe: under match clear it waits for the clearing tick
    logic reload;
    assign reload = clear_on_match_enable ? (tick & evt.match1) : match1Evt;

    // compare registers with double buffering
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            compareActive <= '0;
            compareBuffer <= '0;
        end else begin
            if (wrCmp0) begin
                compareBuffer.cmp0 <= avs_writedata[CW-1:0];
            end
            if (wrCmp1) begin
                compareBuffer.cmp1 <= avs_writedata[CW-1:0];
            end
            if (!buffer_enable_bit || !count_run_bit) begin
                if (wrCmp0) begin
                    compareActive.cmp0 <= avs_writedata[CW-1:0];
                end
                if (wrCmp1) begin
                    compareActive.cmp1 <= avs_writedata[CW-1:0];
                end
            end else if (reload) begin
                compareActive <= compareBuffer;
            end
        end
    end

    // hardware capture events by mode
    logic hwCap0;
    logic hwCap1;
    always_comb begin
        hwCap0 = 1'b0;
        hwCap1 = 1'b0;
        case (capture_timing_select)
            CCT_CPM_RISE: begin
                hwCap0 = pinRise;
            end
            CCT_CPM_BOTH: begin
                hwCap0 = pinRise;
                hwCap1 = pinFall;
            end
            CCT_CPM_MATCH: begin
                hwCap0 = match0Evt;
                hwCap1 = match1Evt;
            end
            default: begin
                hwCap0 = 1'b0;
                hwCap1 = 1'b0;
            end
        endcase
    end
    assign evt.cap0 = hwCap0 | swCapture;
    assign evt.cap1 = hwCap1;

    // capture registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            capture_value_zero <= '0;
            capture_value_one  <= '0;
        end else begin
            if (evt.cap0) begin
                capture_value_zero <= up_counter;
            end
            if (evt.cap1) begin
                capture_value_one <= up_counter;
            end
        end
    end

    // toggle enables
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            toggleEnable <= '0;
        end else if (wrFlop) begin
            toggleEnable <= avs_writedata[CCT_B_TEN +: 4];
        end
    end

    // output flop: software command wins over event toggles
    logic flopToggle;
    assign flopToggle = (toggleEnable[0] & match0Evt) ^ (toggleEnable[1] & match1Evt)
                        ^ (toggleEnable[2] & evt.cap0) ^ (toggleEnable[3] & evt.cap1);
    always_ff @(posedge clk) begin
        // no reset: value stays undefined until software sets or clears it
        if (wrFlop) begin
            case (avs_writedata[CCT_B_FCMD +: 2])
                CCT_FF_TOGGLE: output_toggle_flop <= ~output_toggle_flop;
                CCT_FF_SET:    output_toggle_flop <= 1'b1;
                CCT_FF_CLEAR:  output_toggle_flop <= 1'b0;
                default:       output_toggle_flop <= output_toggle_flop ^ flopToggle;
            endcase
        end else begin
            output_toggle_flop <= output_toggle_flop ^ flopToggle;
        end
    end
    assign timer_output_pin = output_toggle_flop;

    // interrupt pulses
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timer_interrupt        <= 1'b0;
            capture_zero_interrupt <= 1'b0;
            capture_one_interrupt  <= 1'b0;
        end else begin
            timer_interrupt        <= match0Evt | match1Evt | evt.ovf;
            capture_zero_interrupt <= evt.cap0;
            capture_one_interrupt  <= evt.cap1;
        end
    end

    // sticky event status, write one to clear, set wins
    logic [4:0] evtVec;
    assign evtVec = {evt.ovf, evt.cap1, evt.cap0, match1Evt, match0Evt};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stickyStat <= '0;
        end else begin
            stickyStat <= (stickyStat & ~(wrStat ? avs_writedata[4:0] : 5'h00)) | evtVec;
        end
    end
endmodule : cct_timer

/* verification/cct_timer_chk.sv */
// Purpose: port-level assertions for the timer channel
// Assumes: run, mode and flop fields sit in byte lane 0
// Notes:   helper logic mirrors the run bit and capture mode
`timescale 1ns/1ps
module cct_timer_chk
    import cct_pkg::*;
#(
    parameter int CW = CCT_CW
) (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        event_input_pin,
    input wire logic        timer_output_pin,
    input wire logic        timer_interrupt,
    input wire logic        capture_zero_interrupt,
    input wire logic        capture_one_interrupt
);
    logic       regWr;
    logic       runOn;
    logic [1:0] capMode;
    logic [2:0] stopCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // byte lane 0 write strobe
    assign regWr = avs_write && avs_byteenable[0];

    // mirror of run bit and capture mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            runOn   <= 1'b0;
            capMode <= 2'h0;
        end else begin
            if (regWr && avs_address == CCT_OFS_RUN) runOn <= avs_writedata[0];
            if (regWr && avs_address == CCT_OFS_MODE) capMode <= avs_writedata[CCT_B_CPM +: 2];
        end
    end

    // cycles spent stopped, saturating
    always_ff @(posedge clk) begin
        if (sys_rst || runOn) begin
            stopCnt <= 3'h0;
        end else if (stopCnt != 3'h7) begin
            stopCnt <= stopCnt + 3'h1;
        end
    end

    sequence sRdDone(logic [7:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence sFlopCmd(logic [1:0] c);
        regWr && avs_address == CCT_OFS_FLOP && avs_writedata[5:0] == {4'h0, c};
    endsequence

    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write request stalled");
    a_read_wait: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read answer late");
    a_data_hold: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && avs_address > CCT_OFS_STAT |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_snap_width: assert property (sRdDone(CCT_OFS_SNAP) |-> avs_readdata[31:CW] == '0)
        else $error("count wider than counter");
    a_stop_clear: assert property (sRdDone(CCT_OFS_SNAP) ##0 stopCnt == 3'h7
        |-> avs_readdata == 32'h0)
        else $error("stopped count not zero");
    a_stop_quiet: assert property (stopCnt == 3'h7 |-> !timer_interrupt)
        else $error("timer event while stopped");
    a_flop_set: assert property (sFlopCmd(CCT_FF_SET) |=> timer_output_pin)
        else $error("flop set failed");
    a_flop_clear: assert property (sFlopCmd(CCT_FF_CLEAR) |=> !timer_output_pin)
        else $error("flop clear failed");
    a_flop_toggle: assert property (sFlopCmd(CCT_FF_TOGGLE)
        |=> timer_output_pin != $past(timer_output_pin))
        else $error("flop toggle failed");
    a_flop_hold: assert property (sFlopCmd(2'h3) |=> $stable(timer_output_pin))
        else $error("flop changed on no-op command");
    a_swcap_irq: assert property (regWr && avs_address == CCT_OFS_MODE
        && !avs_writedata[CCT_B_SWCAP] |-> ##[1:2] capture_zero_interrupt)
        else $error("software capture gave no event");
    a_cap1_mode: assert property (capture_one_interrupt |-> capMode[1])
        else $error("capture one event in wrong mode");
endmodule : cct_timer_chk

bind cct_timer cct_timer_chk #(.CW(CW)) i_cct_timer_chk (
    .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_input_pin(event_input_pin),
    .timer_output_pin(timer_output_pin), .timer_interrupt(timer_interrupt),
    .capture_zero_interrupt(capture_zero_interrupt),
    .capture_one_interrupt(capture_one_interrupt)
);

/* verification/cct_pin_model.sv */
// Purpose: external event source driving the event input pin
// Assumes: pulses are slow against the two-flop synchroniser
// Notes:   pin rests low between bursts
`timescale 1ns/1ps
module cct_pin_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] edgeReq,
    output logic            eventPin,
    output logic            busy
);
    logic [3:0] left  = 4'h0;
    logic [2:0] phase = 3'h0;

    // four cycles high, four low, per requested pulse
    always_ff @(posedge clk) begin
        if (go) begin
            left  <= edgeReq;
            phase <= 3'h0;
        end else if (left != 4'h0) begin
            phase <= phase + 3'h1;
            if (phase == 3'h7) left <= left - 4'h1;
        end
    end

    assign eventPin = (left != 4'h0) && !phase[2];
    assign busy     = go || (left != 4'h0);
endmodule : cct_pin_model

/* verification/cct_timer_tb_top.sv */
// Purpose: self-checking bench for the capture compare timer
// Assumes: narrow counter width keeps overflow short
// Notes:   reads queue expected data for the monitor
`timescale 1ns/1ps
module cct_timer_tb_top
    import cct_pkg::*;
;
    localparam int TW = 8;
    logic        clk = 1'b0;
    logic        sysRst;
    logic [7:0]  address;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    logic        waitReq;
    logic        pinOut;
    logic        tIrq;
    int          irqCount = 0;
    logic        evtPin;
    logic        go;
    logic        busy;
    logic [3:0]  edgeReq;
    logic [31:0] rnd = 32'h0000_7e52;
    logic [31:0] expQ[$];
    string       nameQ[$];
    int          failures = 0;
    int          checkCount = 0;
    int          cycles = 0;
    logic [7:0]  rstOfs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                                 8'h14, 8'h18, 8'h1C, 8'h20, 8'h40};
    logic [1:0]  ffCmd [5] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h0};
    logic        ffExp [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    cct_timer #(.CW(TW)) i_cct_timer (
        .clk(clk), .sys_rst(sysRst), .avs_address(address), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(waitReq), .event_input_pin(evtPin),
        .timer_output_pin(pinOut), .timer_interrupt(tIrq), .capture_zero_interrupt(),
        .capture_one_interrupt()
    );
    cct_pin_model i_cct_pin_model (
        .clk(clk), .go(go), .edgeReq(edgeReq), .eventPin(evtPin), .busy(busy)
    );

    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        wdata   <= d;
        wr      <= 1'b1;
        do @(posedge clk); while (waitReq !== 1'b0);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        expQ.push_back(exp);
        nameQ.push_back(what);
        @(posedge clk);
        address <= a;
        rd      <= 1'b1;
        do @(posedge clk); while (waitReq !== 1'b0);
        rd <= 1'b0;
    endtask : rd_reg

    task automatic pulse(input logic [3:0] n);
        @(posedge clk);
        edgeReq <= n;
        go      <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        do @(posedge clk); while (busy);
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic close_out();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    // pair each finished read with the oldest note
    always @(posedge clk) begin
        if (rd === 1'b1 && waitReq === 1'b0 && expQ.size() > 0) begin
            check(nameQ.pop_front(), rdata, expQ.pop_front());
        end
    end

    // timer event pulse count
    always @(posedge clk) begin
        if (tIrq === 1'b1) irqCount++;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            failures++;
            close_out();
        end
    end

    initial begin
        sysRst  = 1'b1;
        rd      = 1'b0;
        wr      = 1'b0;
        address = 8'h00;
        wdata   = 32'h0;
        be      = 4'hF;
        go      = 1'b0;
        edgeReq = 4'h0;
        repeat (20) @(posedge clk);
        sysRst <= 1'b0;
        // reset values and an unmapped place
        for (int i = 0; i < 10; i++) begin
            rd_reg(rstOfs[i], (i == 1) ? 32'h20 : (i == 3) ? 32'h3 : 32'h0, "reset value");
        end
        rnd = next_rand(rnd);
        wr_reg(8'h40, rnd);
        rd_reg(8'h40, 32'h0, "unmapped");
        // every flop command while stopped
        for (int i = 0; i < 5; i++) begin
            wr_reg(CCT_OFS_FLOP, {30'h0, ffCmd[i]});
            @(negedge clk);
            check("flop pin", {31'h0, pinOut}, {31'h0, ffExp[i]});
            rd_reg(CCT_OFS_STAT, {26'h0, ffExp[i], 5'h0}, "flop status");
        end
        // buffered compare written while stopped lands at once
        wr_reg(CCT_OFS_CTRL, 32'h80);
        rnd = next_rand(rnd);
        wr_reg(CCT_OFS_CMP0, rnd);
        rd_reg(CCT_OFS_CMP0, {24'h0, rnd[7:0]}, "stopped compare");
        // pin edges, falling capture, software capture, stop
        wr_reg(CCT_OFS_MODE, 32'h30);
        wr_reg(CCT_OFS_RUN, 32'h1);
        pulse(4'h5);
        rd_reg(CCT_OFS_SNAP, 32'h5, "pin count");
        rd_reg(CCT_OFS_CAP1, 32'h5, "fall capture");
        wr_reg(CCT_OFS_MODE, 32'h10);
        rd_reg(CCT_OFS_CAP0, 32'h5, "soft capture");
        wr_reg(CCT_OFS_RUN, 32'h0);
        repeat (8) @(posedge clk);
        rd_reg(CCT_OFS_SNAP, 32'h0, "stopped count");
        // clear on compare one with buffered reload
        wr_reg(CCT_OFS_CMP0, 32'h1);
        wr_reg(CCT_OFS_CMP1, 32'h3);
        wr_reg(CCT_OFS_FLOP, 32'h0A);
        wr_reg(CCT_OFS_MODE, 32'h3C);
        wr_reg(CCT_OFS_RUN, 32'h1);
        wr_reg(CCT_OFS_CMP1, 32'h2);
        rd_reg(CCT_OFS_CMP1, 32'h3, "held compare");
        pulse(4'h4);
        rd_reg(CCT_OFS_SNAP, 32'h0, "cleared count");
        rd_reg(CCT_OFS_CAP0, 32'h1, "match0 capture");
        rd_reg(CCT_OFS_CAP1, 32'h3, "match1 capture");
        rd_reg(CCT_OFS_CMP1, 32'h2, "reloaded compare");
        check("match toggle", {31'h0, pinOut}, 32'h1);
        pulse(4'h2);
        rd_reg(CCT_OFS_SNAP, 32'h2, "count after reload");
        check("match toggle", {31'h0, pinOut}, 32'h0);
        // free run on the fastest tap until overflow
        wr_reg(CCT_OFS_RUN, 32'h0);
        wr_reg(CCT_OFS_FLOP, 32'h02);
        wr_reg(CCT_OFS_STAT, 32'h1F);
        wr_reg(CCT_OFS_CTRL, 32'h0);
        wr_reg(CCT_OFS_MODE, 32'h21);
        irqCount = 0;
        wr_reg(CCT_OFS_RUN, 32'h1);
        repeat (600) @(posedge clk);
        check("timer events", irqCount, 32'h5);
        rd_reg(CCT_OFS_STAT, 32'h13, "overflow status");
        repeat (4) @(posedge clk);
        close_out();
    end
endmodule : cct_timer_tb_top
